// ---- core/core_interrupt_and_wakeup.sv ----
// Interrupt register bank, per-core software interrupts and latch wakeup detector.
// Assumes sources are asynchronous levels; cores, power unit and bus share clk_in.
//
// The strobed register port was chosen for this implementation.
module core_interrupt_and_wakeup
    import irq_wake_pkg::*;
#(
    parameter int WAKE_CYCLES_P = WAKE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire bus_req_type bus_in,
    output logic [31:0] rdata_out,
    input wire logic [NUM_IRQ-1:0] irq_src_in,
    input wire logic core_ack_in,
    input wire logic core_done_in,
    input wire logic [7:0] core_done_id_in,
    output logic irq_req_out,
    output logic [7:0] irq_id_out,
    output logic [NUM_CORES-1:0] soft_irq_out,
    input wire logic deep_sleep_in,
    input wire logic wake_ack_in,
    output logic wake_req_out,
    output logic sleep_ok_out,
    output logic irq_out
);

    // Word inside a 32-byte bank of eight registers
    function automatic logic in_bank(input logic [31:0] a, input logic [31:0] base);
        return (a[31:5] == base[31:5]) && (a[1:0] == 2'b00);
    endfunction : in_bank

    // One-hot mask for a line number
    function automatic logic [NUM_IRQ-1:0] line_mask(input logic [7:0] id);
        logic [NUM_IRQ-1:0] m;
        m = '0;
        m[id] = 1'b1;
        return m;
    endfunction : line_mask

    logic [IRQ_BANKS-1:0][31:0] en_q, en_d;
    logic [IRQ_BANKS-1:0][31:0] pend_q, pend_d;
    logic [IRQ_BANKS-1:0][31:0] act_q, act_d;
    logic [IRQ_BANKS-1:0][31:0] prio_q, prio_d;
    logic [IRQ_BANKS-1:0][31:0] src_s1_q, src_s2_q;
    logic [NUM_CORES-1:0][31:0] soft_q, soft_d;
    logic [EV_BITS-1:0] ev_q, ev_d, ev_mask_q, ev_set;
    logic [31:0] rdata_q, rd_word;
    logic irq_req_q, irq_req_d;
    logic [7:0] irq_id_q, sel_id;
    logic sel_found;
    logic [SETTLE_W-1:0] settle_q, settle_d;
    logic wake_lat;
    logic wake_s1_q, wake_s2_q, wake_s3_q;
    logic [NUM_IRQ-1:0] cand, take_mask, done_mask, pclr_mask, pset_mask;

    // Address decode
    wire [2:0] widx = bus_in.addr[4:2];
    wire hit_type_info = bus_in.addr == TYPE_INFO_ADDR;
    wire hit_en_set = in_bank(bus_in.addr, EN_SET_BASE);
    wire hit_en_clr = in_bank(bus_in.addr, EN_CLR_BASE);
    wire hit_p_set = in_bank(bus_in.addr, PEND_SET_BASE);
    wire hit_p_clr = in_bank(bus_in.addr, PEND_CLR_BASE);
    wire hit_act = in_bank(bus_in.addr, ACTIVE_BASE);
    wire hit_prio = in_bank(bus_in.addr, PRIO_BASE);
    wire hit_s0_stat = bus_in.addr == SOFT0_STAT_ADDR;
    wire hit_s0_set = bus_in.addr == SOFT0_SET_ADDR;
    wire hit_s0_clr = bus_in.addr == SOFT0_CLR_ADDR;
    wire hit_s1_stat = bus_in.addr == SOFT1_STAT_ADDR;
    wire hit_s1_set = bus_in.addr == SOFT1_SET_ADDR;
    wire hit_s1_clr = bus_in.addr == SOFT1_CLR_ADDR;
    wire hit_ev_stat = bus_in.addr == EV_STAT_ADDR;
    wire hit_ev_mask = bus_in.addr == EV_MASK_ADDR;
    wire hit_soft = hit_s0_stat | hit_s0_set | hit_s0_clr | hit_s1_stat | hit_s1_set | hit_s1_clr;
    wire mapped = hit_type_info | hit_en_set | hit_en_clr | hit_p_set | hit_p_clr | hit_act
                  | hit_prio | hit_soft | hit_ev_stat | hit_ev_mask;
    wire bad_access = (bus_in.we | bus_in.re) & ~mapped;

    // Handshake with the core
    wire take = core_ack_in & irq_req_q;
    assign take_mask = take ? line_mask(irq_id_q) : '0;
    assign done_mask = core_done_in ? line_mask(core_done_id_in) : '0;

    // Pending set and clear masks from software
    assign pset_mask = (bus_in.we & hit_p_set) ? NUM_IRQ'(bus_in.wdata) << (widx * 32) : '0;
    assign pclr_mask = (bus_in.we & hit_p_clr) ? NUM_IRQ'(bus_in.wdata) << (widx * 32) : '0;

    // Next state of the line banks
    always_comb begin
        en_d = en_q;
        prio_d = prio_q;
        if (bus_in.we && hit_en_set) begin
            en_d[widx] = en_q[widx] | bus_in.wdata;
        end
        if (bus_in.we && hit_en_clr) begin
            en_d[widx] = en_q[widx] & ~bus_in.wdata;
        end
        if (bus_in.we && hit_prio) begin
            prio_d[widx] = bus_in.wdata;
        end
        // Set beats clear for pending and active lines
        pend_d = (pend_q & ~(pclr_mask | take_mask)) | pset_mask | src_s2_q;
        act_d = (act_q & ~done_mask) | take_mask;
    end

    // Lowest numbered enabled pending line that is not active
    assign cand = pend_q & en_q & ~act_q;
    always_comb begin
        sel_id = 8'h00;
        sel_found = 1'b0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (cand[i]) begin
                sel_id = 8'(i);
                sel_found = 1'b1;
            end
        end
    end

    // Request held back while waking and right after a take
    assign irq_req_d = sel_found & ~take & ~deep_sleep_in & (settle_q == '0);

    // Settling count reloaded throughout sleep, counted down after wake
    assign settle_d = deep_sleep_in ? SETTLE_W'(WAKE_CYCLES_P) :
                      (settle_q != '0) ? settle_q - 1'b1 : settle_q;

    // Per-core software interrupts, write one to set or clear
    always_comb begin
        soft_d = soft_q;
        if (bus_in.we && hit_s0_set) begin
            soft_d[0] = soft_q[0] | bus_in.wdata;
        end
        if (bus_in.we && hit_s0_clr) begin
            soft_d[0] = soft_q[0] & ~bus_in.wdata;
        end
        if (bus_in.we && hit_s1_set) begin
            soft_d[1] = soft_q[1] | bus_in.wdata;
        end
        if (bus_in.we && hit_s1_clr) begin
            soft_d[1] = soft_q[1] & ~bus_in.wdata;
        end
    end

    // Event status, write one clears, new event wins
    assign ev_set[EV_WAKE] = wake_s2_q & ~wake_s3_q;
    assign ev_set[EV_BAD_ADDR] = bad_access;
    assign ev_set[EV_SOFT] = bus_in.we & (hit_s0_set | hit_s1_set) & (bus_in.wdata != '0);
    assign ev_d = (bus_in.we && hit_ev_stat) ? ((ev_q & ~bus_in.wdata[EV_BITS-1:0]) | ev_set)
                                              : (ev_q | ev_set);

    // Read selection
    always_comb begin
        rd_word = 32'h00000000;
        if (hit_type_info) begin
            rd_word = TYPE_INFO_VALUE;
        end else if (hit_en_set || hit_en_clr) begin
            rd_word = en_q[widx];
        end else if (hit_p_set || hit_p_clr) begin
            rd_word = pend_q[widx];
        end else if (hit_act) begin
            rd_word = act_q[widx];
        end else if (hit_prio) begin
            rd_word = prio_q[widx];
        end else if (hit_s0_stat || hit_s0_set) begin
            rd_word = soft_q[0];
        end else if (hit_s1_stat || hit_s1_set) begin
            rd_word = soft_q[1];
        end else if (hit_ev_stat) begin
            rd_word = {29'h0, ev_q};
        end else if (hit_ev_mask) begin
            rd_word = {29'h0, ev_mask_q};
        end
    end

    // Source synchronisers
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            src_s1_q <= '0;
            src_s2_q <= '0;
        end else begin
            src_s1_q <= irq_src_in;
            src_s2_q <= src_s1_q;
        end
    end

    // Line banks
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            en_q <= {IRQ_BANKS{BANK_RESET}};
            pend_q <= {IRQ_BANKS{BANK_RESET}};
            act_q <= {IRQ_BANKS{BANK_RESET}};
            prio_q <= {IRQ_BANKS{BANK_RESET}};
        end else begin
            en_q <= en_d;
            pend_q <= pend_d;
            act_q <= act_d;
            prio_q <= prio_d;
        end
    end

    // Core request, software interrupts, events and read port
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_req_q <= 1'b0;
            irq_id_q <= 8'h00;
            settle_q <= '0;
            soft_q <= '0;
            ev_q <= EV_RESET;
            ev_mask_q <= EV_RESET;
            rdata_q <= 32'h00000000;
        end else begin
            irq_req_q <= irq_req_d;
            irq_id_q <= irq_req_d ? sel_id : irq_id_q;
            settle_q <= settle_d;
            soft_q <= soft_d;
            ev_q <= ev_d;
            ev_mask_q <= (bus_in.we && hit_ev_mask) ? bus_in.wdata[EV_BITS-1:0] : ev_mask_q;
            rdata_q <= bus_in.re ? rd_word : 32'h00000000;
        end
    end

    // Wakeup latch: set by a raw enabled line in sleep, works with clock gated
    wire wake_set = deep_sleep_in & (|(irq_src_in & en_q));
    wire wake_clr = wake_ack_in & ~deep_sleep_in;
    always_latch begin
        if (!rstn_in) begin
            wake_lat = 1'b0;
        end else if (wake_set) begin
            wake_lat = 1'b1;
        end else if (wake_clr) begin
            wake_lat = 1'b0;
        end
    end

    // Wake latch brought into the clock domain for the event bit
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
            wake_s3_q <= 1'b0;
        end else begin
            wake_s1_q <= wake_lat;
            wake_s2_q <= wake_s1_q;
            wake_s3_q <= wake_s2_q;
        end
    end

    // Outputs
    assign rdata_out = rdata_q;
    assign irq_req_out = irq_req_q;
    assign irq_id_out = irq_id_q;
    assign soft_irq_out[0] = |soft_q[0];
    assign soft_irq_out[1] = |soft_q[1];
    assign wake_req_out = wake_lat;
    assign sleep_ok_out = deep_sleep_in & ~wake_lat;
    assign irq_out = |(ev_q & ev_mask_q);

    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    // Register bank checks
    a_type_read: assert property (
        bus_in.re && hit_type_info |=> rdata_out == TYPE_INFO_VALUE)
        else $error("type word read wrong");
    a_bad_event: assert property (
        bad_access |=> ev_q[EV_BAD_ADDR])
        else $error("unmapped access not flagged");
    a_bad_read_zero: assert property (
        bad_access && bus_in.re |=> rdata_out == 32'h00000000)
        else $error("unmapped read not zero");
    a_en_set_write: assert property (
        bus_in.we && bus_in.addr == EN_SET_BASE && bus_in.wdata[3] |=> en_q[0][3])
        else $error("enable set lost");
    a_en_clr_write: assert property (
        bus_in.we && bus_in.addr == EN_CLR_BASE |=> (en_q[0] & $past(bus_in.wdata)) == '0)
        else $error("enable clear failed");
    a_pend_set_write: assert property (
        bus_in.we && bus_in.addr == PEND_SET_BASE |=> (pend_q[0] & $past(bus_in.wdata))
        == $past(bus_in.wdata))
        else $error("pending set lost");
    a_pend_clr_write: assert property (
        bus_in.we && bus_in.addr == PEND_CLR_BASE && bus_in.wdata[0] && !src_s2_q[0][0]
        |=> !pend_q[0][0])
        else $error("pending clear failed");
    a_take_active: assert property (
        take && !core_done_in |=> act_q[$past(irq_id_q) >> 5][$past(irq_id_q[4:0])]
        && !irq_req_out)
        else $error("taken line not active");
    a_done_clears: assert property (
        core_done_in && !take
        |=> !act_q[$past(core_done_id_in) >> 5][$past(core_done_id_in[4:0])])
        else $error("finished line still active");
    a_active_ro: assert property (
        bus_in.we && hit_act && !take && !core_done_in |=> act_q == $past(act_q))
        else $error("active bank changed by write");
    a_prio_write: assert property (
        bus_in.we && hit_prio |=> prio_q[$past(widx)] == $past(bus_in.wdata))
        else $error("priority word not stored");

    // Software interrupt checks
    a_soft_clear_keep: assert property (
        bus_in.we && hit_s0_clr |=> soft_q[0] == ($past(soft_q[0]) & ~$past(bus_in.wdata)))
        else $error("soft clear touched other bits");
    a_soft_set_keep: assert property (
        bus_in.we && hit_s0_set |=> soft_q[0] == ($past(soft_q[0]) | $past(bus_in.wdata)))
        else $error("soft set touched other bits");
    a_soft1_clear: assert property (
        bus_in.we && hit_s1_clr |=> soft_q[1] == ($past(soft_q[1]) & ~$past(bus_in.wdata)))
        else $error("second core clear wrong");
    a_soft_set_read: assert property (
        bus_in.we && hit_s1_set ##2 bus_in.re && hit_s1_stat
        |=> (rdata_out & $past(bus_in.wdata, 3)) == $past(bus_in.wdata, 3))
        else $error("soft set not read back");

    // Wakeup and sleep checks
    a_wake_only_sleep: assert property (
        $rose(wake_req_out) |-> $past(deep_sleep_in) || deep_sleep_in)
        else $error("wake outside sleep");
    a_wake_set: assert property (
        deep_sleep_in && (|(irq_src_in & en_q)) |-> wake_req_out)
        else $error("enabled line did not wake");
    a_wake_hold: assert property (
        $fell(wake_req_out) |-> wake_ack_in && !deep_sleep_in)
        else $error("wake request dropped early");
    a_settle_gate: assert property (
        $fell(deep_sleep_in) |-> !irq_req_out [*2])
        else $error("request during wake settle");
    a_no_req_sleep: assert property (
        deep_sleep_in && $past(deep_sleep_in) |-> !irq_req_out)
        else $error("request offered in sleep");
    a_sleep_gate_ok: assert property (
        sleep_ok_out |-> deep_sleep_in && !wake_req_out)
        else $error("gate allowed while waking");

    // Main scenario covers
    c_wake: cover property (deep_sleep_in && wake_req_out ##[1:20] !deep_sleep_in);
    c_settle: cover property ($fell(deep_sleep_in) ##[1:10] irq_req_out);
    c_take: cover property (irq_req_out && core_ack_in);
    c_soft: cover property (bus_in.we && hit_s0_set ##1 soft_irq_out[0]);
    c_bad: cover property (bad_access ##1 irq_out);

endmodule : core_interrupt_and_wakeup

// ---- core/irq_wake_pkg.sv ----
// Constants, address map and bus carrier of the interrupt and wakeup block.
// Assumes a single 125 MHz clock and a simple strobe register port.
// Notes on behaviour
// - Read-only controller type word, fixed address
// - Eight enable-set words, reset zero
// - Eight enable-clear words, reset zero
// - Eight pending-set words, reset zero
// - Eight pending-clear words, reset zero
// - Eight read-only active words, reset zero
// - Eight priority words, reset zero
// - Software raises, clears, reads core interrupts
// - Per-core bits set and cleared independently
// - Each core owns status, set, clear
// - Wakeup detector senses interrupt, ends sleep
// - Wakeup detector works only in sleep
// - Wakeup detector has no software controls
// - Power unit may gate core while armed
// - Wake takes several cycles before service
// - Wakeup detector built from latches
package irq_wake_pkg;
    localparam int IRQ_BANKS = 8;
    localparam int NUM_IRQ = IRQ_BANKS * 32;
    localparam int NUM_CORES = 2;
    // Controller map, byte addresses
    localparam logic [31:0] TYPE_INFO_ADDR = 32'he000e004;
    localparam logic [31:0] EN_SET_BASE = 32'he000e100;
    localparam logic [31:0] EN_CLR_BASE = 32'he000e180;
    localparam logic [31:0] PEND_SET_BASE = 32'he000e200;
    localparam logic [31:0] PEND_CLR_BASE = 32'he000e280;
    localparam logic [31:0] ACTIVE_BASE = 32'he000e300;
    localparam logic [31:0] PRIO_BASE = 32'he000e400;
    // Per-core software interrupt and event registers
    localparam logic [31:0] SOFT0_STAT_ADDR = 32'he000f000;
    localparam logic [31:0] SOFT0_SET_ADDR = 32'he000f004;
    localparam logic [31:0] SOFT0_CLR_ADDR = 32'he000f008;
    localparam logic [31:0] SOFT1_STAT_ADDR = 32'he000f010;
    localparam logic [31:0] SOFT1_SET_ADDR = 32'he000f014;
    localparam logic [31:0] SOFT1_CLR_ADDR = 32'he000f018;
    localparam logic [31:0] EV_STAT_ADDR = 32'he000f020;
    localparam logic [31:0] EV_MASK_ADDR = 32'he000f024;
    // Event bit positions
    localparam int EV_WAKE = 0;
    localparam int EV_BAD_ADDR = 1;
    localparam int EV_SOFT = 2;
    localparam int EV_BITS = 3;
    // Reset values
    localparam logic [31:0] BANK_RESET = 32'h00000000;
    localparam logic [EV_BITS-1:0] EV_RESET = 3'h0;
    // Controller type word: line banks minus one in the low nibble
    localparam logic [31:0] TYPE_INFO_VALUE = 32'h00000007;
    // Wake settling time
    localparam int CLK_PERIOD_NS = 8;
    localparam int WAKE_TIME_NS = 32;
    localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 8;

    // Register port request
    typedef struct packed {
        logic we;
        logic re;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bus_req_type;
endpackage : irq_wake_pkg

// ---- dv/core_interrupt_and_wakeup_tb.sv ----
// Self-checking bench of the interrupt and wakeup block, seeded random data.
// Assumes the core side model; the bench plays bus master, sources and power unit.
module core_interrupt_and_wakeup_tb;
    import irq_wake_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WC = 3;
    localparam logic [31:0] BASES [6] = '{EN_SET_BASE, EN_CLR_BASE, PEND_SET_BASE,
        PEND_CLR_BASE, ACTIVE_BASE, PRIO_BASE};
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    bus_req_type bus = '0;
    logic [NUM_IRQ-1:0] src = '0;
    logic deep_sleep = 1'b0;
    logic slow = 1'b0;
    logic [31:0] rdata_out, r, m;
    logic [7:0] irq_id_out, done_id;
    logic [1:0] soft_irq_out;
    logic irq_req_out, wake_req_out, sleep_ok_out, irq_out, ack, done, wake_ack;
    int err_count = 0;
    int check_count = 0;
    int n;

    // Clock, 8 ns period
    always #4 clk_in = ~clk_in;

    core_interrupt_and_wakeup #(.WAKE_CYCLES_P(WC)) i_core_interrupt_and_wakeup (
        .clk_in(clk_in), .rstn_in(rstn_in), .bus_in(bus), .rdata_out(rdata_out),
        .irq_src_in(src), .core_ack_in(ack), .core_done_in(done),
        .core_done_id_in(done_id), .irq_req_out(irq_req_out), .irq_id_out(irq_id_out),
        .soft_irq_out(soft_irq_out), .deep_sleep_in(deep_sleep), .wake_ack_in(wake_ack),
        .wake_req_out(wake_req_out), .sleep_ok_out(sleep_ok_out), .irq_out(irq_out));

    core_side_model i_core_side_model (
        .clk_in(clk_in), .rstn_in(rstn_in), .slow_in(slow), .irq_req_in(irq_req_out),
        .irq_id_in(irq_id_out), .wake_req_in(wake_req_out), .deep_sleep_in(deep_sleep),
        .core_ack_out(ack), .core_done_out(done), .core_done_id_out(done_id),
        .wake_ack_out(wake_ack));

    // Expected value after set and clear masks
    function automatic logic [31:0] keep_bits(input logic [31:0] old, s, c);
        return (old | s) & ~c;
    endfunction : keep_bits

    function automatic logic [31:0] bit_of(input int k);
        return 32'h1 << k[4:0];
    endfunction : bit_of

    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // Bus cycles; each leaves one idle cycle behind it
    task automatic wr(input logic [31:0] a, d);
        bus.we <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge clk_in);
        bus.we <= 1'b0;
        @(posedge clk_in);
    endtask : wr

    task automatic rc(input logic [31:0] a, e);
        bus.re <= 1'b1;
        bus.addr <= a;
        @(posedge clk_in);
        bus.re <= 1'b0;
        @(negedge clk_in);
        chk(rdata_out, e);
        @(posedge clk_in);
    endtask : rc

    task automatic wait_req();
        for (int k = 0; k < 20 && irq_req_out !== 1'b1; k++) @(negedge clk_in);
        chk(irq_req_out, 1'b1);
    endtask : wait_req

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // Watchdog against a hung sequence
    initial begin
        repeat (50000) @(posedge clk_in);
        err_count++;
        close_out();
    end

    // Main sequence
    initial begin
        void'($urandom(51));
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        for (int b = 0; b < 6; b++) begin
            for (int i = 0; i < IRQ_BANKS; i++) begin
                rc(BASES[b] + 32'(4 * i), BANK_RESET);
            end
        end
        for (int i = 0; i < IRQ_BANKS; i++) begin
            for (int b = 0; b < 4; b += 2) begin
                r = (i == 7) ? 32'hffffffff : $urandom;
                m = $urandom;
                wr(BASES[b] + 32'(4 * i), r);
                rc(BASES[b + 1] + 32'(4 * i), r);
                wr(BASES[b + 1] + 32'(4 * i), m);
                wr(BASES[b] + 32'(4 * i), 32'h0);
                rc(BASES[b] + 32'(4 * i), keep_bits(r, 32'h0, m));
                wr(BASES[b + 1] + 32'(4 * i), 32'hffffffff);
            end
            r = $urandom;
            wr(PRIO_BASE + 32'(4 * i), r);
            wr(ACTIVE_BASE + 32'(4 * i), 32'hffffffff);
            rc(PRIO_BASE + 32'(4 * i), r);
            rc(ACTIVE_BASE + 32'(4 * i), 32'h0);
        end
        wr(TYPE_INFO_ADDR, 32'h0);
        rc(TYPE_INFO_ADDR, TYPE_INFO_VALUE);
        // Reserved address reads zero and raises an unmasked event
        wr(EV_MASK_ADDR, 32'h2);
        rc(32'he000e020, 32'h0);
        @(negedge clk_in);
        chk(irq_out, 1'b1);
        @(posedge clk_in);
        rc(EV_STAT_ADDR, 32'h2);
        wr(EV_STAT_ADDR, 32'h2);
        rc(EV_STAT_ADDR, 32'h0);
        // Per-core software interrupt words
        for (int c = 0; c < NUM_CORES; c++) begin
            logic [31:0] b;
            b = (c == 1) ? SOFT1_STAT_ADDR : SOFT0_STAT_ADDR;
            r = $urandom | 32'h1;
            m = $urandom;
            rc(b, 32'h0);
            wr(b + 32'h4, r);
            rc(b, r);
            rc(b + 32'h4, r);
            @(negedge clk_in);
            chk(soft_irq_out[c], 1'b1);
            @(posedge clk_in);
            wr(b + 32'h8, m);
            wr(b + 32'h4, 32'h0);
            rc(b, keep_bits(r, 32'h0, m));
            wr(b + 32'h8, 32'hffffffff);
        end
        // Two neighbouring lines pending, slow core takes the lower first
        n = 32 * $urandom_range(7, 0) + $urandom_range(30, 0);
        slow <= 1'b1;
        wr(EN_SET_BASE + 32'(4 * (n / 32)), 32'h3 << (n % 32));
        wr(PEND_SET_BASE + 32'(4 * (n / 32)), 32'h3 << (n % 32));
        wait_req();
        chk(irq_id_out, n[7:0]);
        for (int k = 0; k < 20 && ack !== 1'b1; k++) @(negedge clk_in);
        @(posedge clk_in);
        rc(ACTIVE_BASE + 32'(4 * (n / 32)), bit_of(n));
        rc(PEND_SET_BASE + 32'(4 * (n / 32)), bit_of(n + 1));
        repeat (80) @(posedge clk_in);
        rc(ACTIVE_BASE + 32'(4 * (n / 32)), 32'h0);
        // Wakeup from deep sleep through the latch detector
        n = $urandom_range(NUM_IRQ - 1, 0);
        slow <= 1'b0;
        rc(EV_STAT_ADDR, 32'h4);
        wr(EV_STAT_ADDR, 32'h7);
        wr(EN_SET_BASE + 32'(4 * (n / 32)), bit_of(n));
        deep_sleep <= 1'b1;
        @(negedge clk_in);
        chk(sleep_ok_out, 1'b1);
        chk(wake_req_out, 1'b0);
        @(posedge clk_in);
        src[n] <= 1'b1;
        repeat (2) @(negedge clk_in);
        chk(wake_req_out, 1'b1);
        chk(sleep_ok_out, 1'b0);
        @(posedge clk_in);
        src[n] <= 1'b0;
        repeat (6) begin
            @(negedge clk_in);
            chk(wake_req_out, 1'b1);
            chk(irq_req_out, 1'b0);
        end
        @(posedge clk_in);
        rc(EV_STAT_ADDR, 32'h1);
        deep_sleep <= 1'b0;
        repeat (WC) begin
            @(negedge clk_in);
            chk(irq_req_out, 1'b0);
        end
        wait_req();
        chk(irq_id_out, n[7:0]);
        chk(wake_req_out, 1'b0);
        // Detector stays idle while awake
        @(posedge clk_in);
        src[n] <= 1'b1;
        repeat (3) @(negedge clk_in);
        chk(wake_req_out, 1'b0);
        @(posedge clk_in);
        src[n] <= 1'b0;
        repeat (60) @(posedge clk_in);
        close_out();
    end
endmodule : core_interrupt_and_wakeup_tb

// ---- dv/core_side_model.sv ----
// Far-side model: one core that services offered lines and accepts wakeups.
// Assumes the block's clock and reset; slow_in stretches the take delay.
module core_side_model (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic slow_in,
    input wire logic irq_req_in,
    input wire logic [7:0] irq_id_in,
    input wire logic wake_req_in,
    input wire logic deep_sleep_in,
    output logic core_ack_out,
    output logic core_done_out,
    output logic [7:0] core_done_id_out,
    output logic wake_ack_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy_q;
    logic [4:0] cnt_q;
    // Take an offered line after a delay, finish it twenty-one cycles later
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_q <= 1'b0;
            cnt_q <= 5'h0;
            core_ack_out <= 1'b0;
            core_done_out <= 1'b0;
            core_done_id_out <= 8'h0;
            wake_ack_out <= 1'b0;
        end else begin
            core_ack_out <= 1'b0;
            core_done_out <= 1'b0;
            cnt_q <= cnt_q + 5'h1;
            // Accept a wakeup only once the power unit has left sleep
            wake_ack_out <= wake_req_in & ~deep_sleep_in;
            if (!busy_q && !irq_req_in) begin
                cnt_q <= 5'h0;
            end else if (!busy_q && !core_ack_out && cnt_q >= {3'h0, slow_in, 1'b0}) begin
                core_ack_out <= 1'b1;
                core_done_id_out <= irq_id_in;
                busy_q <= 1'b1;
                cnt_q <= 5'h0;
            end else if (busy_q && cnt_q == 5'h14) begin
                core_done_out <= 1'b1;
                busy_q <= 1'b0;
            end
        end
    end
endmodule : core_side_model
